// File: src/clock_frequency_synthesis.sv
// clock manager frequency synthesis, coarse and fine phase, apb slave
//
// Overview of operation
// - doubled clock: twice reference, rising in phase
// - inverted doubled clock: twice reference, half shifted
// - divided clock: reference over divide ratio
// - ratio 1.5..8 half steps, 9..16; aligned
// - doubled and divided outputs have equal halves
// - phase outputs: correction on 50%, off copies
// - before lock doubled runs 25% at reference
// - fractional ratio, high frequency: shorter high
// - synthesized = reference times numerator over denominator
// - numerator 2..32, denominator 1..32
// - inverted synthesized is inverse of synthesized
// - synthesized outputs: high and low halves differ by at most one clock
// - synthesized run alongside all loop outputs
// - synthesizer uses the same reference input
// - no feedback: no delay correction applied
// - synthesized realigns every denominator reference periods
// - four phase outputs give coarse phase control
// - fine shift between feedback and reference
// - fine step: max of period/512, tap
// - fine shift moves all nine outputs
// - lock once zero phase matches reference; with no feedback, once the period is stable
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module clock_frequency_synthesis (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic [clock_synth_pkg::PADDR_W-1:0] paddr,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [clock_synth_pkg::PDATA_W-1:0] pwdata,
    output logic      [clock_synth_pkg::PDATA_W-1:0] prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             reference_clock_in,
    input  wire logic                             feedback_clock_in,
    output logic                                  zero_phase_output,
    output logic                                  quarter_phase_output,
    output logic                                  half_phase_output,
    output logic                                  three_quarter_phase_output,
    output logic                                  doubled_clock,
    output logic                                  doubled_clock_inverted,
    output logic                                  divided_clock,
    output logic                                  synthesized_clock,
    output logic                                  synthesized_clock_inverted,
    output logic                                  lock_indicator
);
    import clock_synth_pkg::*;

    // ==========================================
    // helpers
    function automatic logic [15:0] wrap_sub(input logic [15:0] a, input logic [15:0] b,
                                             input logic [15:0] p);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, p} - {1'b0, b};
        wrap_sub = (a >= b) ? (a - b) : t[15:0];
    endfunction : wrap_sub

    function automatic logic [15:0] wrap_add(input logic [15:0] a, input logic [15:0] b,
                                             input logic [15:0] p);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        wrap_add = (t >= {1'b0, p}) ? 16'(t - {1'b0, p}) : t[15:0];
    endfunction : wrap_add

    function automatic logic mapped(input logic [PADDR_W-1:0] a);
        mapped = (a == CTRL_OFFSET) || (a == SYNTH_OFFSET) || (a == SHIFT_OFFSET) || (a == STATUS_OFFSET);
    endfunction : mapped

    // ==========================================
    // settings
    logic        dcc_enable;
    logic [1:0]  fb_mode;
    logic        high_freq;
    logic [5:0]  divide_ratio_setting;
    logic [5:0]  synth_numerator;
    logic [5:0]  synth_denominator;
    logic [8:0]  phase_shift;
    logic        stable;
    logic        aligned;
    logic [15:0] period;
    logic [PDATA_W-1:0] next_prdata;
    logic        access;
    logic [5:0]  w_div;
    logic [5:0]  w_num;
    logic [5:0]  w_den;
    logic [1:0]  w_fb;
    logic [8:0]  w_shift;

    assign access  = psel && penable && pready;
    assign w_div   = pwdata[CTRL_DIV_LSB +: 6];
    assign w_fb    = pwdata[CTRL_FB_LSB +: 2];
    assign w_num   = pwdata[SYNTH_NUM_LSB +: 6];
    assign w_den   = pwdata[SYNTH_DEN_LSB +: 6];
    assign w_shift = pwdata[8:0];

    // ==========================================
    // apb slave; answers in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (psel && !penable) begin
                prdata <= next_prdata;
            end
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            CTRL_OFFSET: begin
                next_prdata[CTRL_DCC_BIT]      = dcc_enable;
                next_prdata[CTRL_FB_LSB +: 2]  = fb_mode;
                next_prdata[CTRL_HF_BIT]       = high_freq;
                next_prdata[CTRL_DIV_LSB +: 6] = divide_ratio_setting;
            end
            SYNTH_OFFSET: begin
                next_prdata[SYNTH_NUM_LSB +: 6] = synth_numerator;
                next_prdata[SYNTH_DEN_LSB +: 6] = synth_denominator;
            end
            SHIFT_OFFSET: begin
                next_prdata[8:0] = phase_shift;
            end
            STATUS_OFFSET: begin
                next_prdata[STAT_LOCK_BIT]      = lock_indicator;
                next_prdata[STAT_STBL_BIT]      = stable;
                next_prdata[STAT_ALGN_BIT]      = aligned;
                next_prdata[STAT_PER_LSB +: 16] = period;
            end
            default: begin
                next_prdata = 32'h0000_0000;
            end
        endcase
    end

    // out-of-range fields are dropped so the core never sees an illegal ratio
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcc_enable           <= DCC_RESET;
            fb_mode              <= FB_RESET;
            high_freq            <= HF_RESET;
            divide_ratio_setting <= DIV_RESET;
            synth_numerator      <= NUM_RESET;
            synth_denominator    <= DEN_RESET;
            phase_shift          <= SHIFT_RESET;
        end else if (access && pwrite) begin
            if (paddr == CTRL_OFFSET) begin
                dcc_enable <= pwdata[CTRL_DCC_BIT];
                high_freq  <= pwdata[CTRL_HF_BIT];
                if (w_fb != 2'h3) begin
                    fb_mode <= w_fb;
                end
                if ((w_div >= DIV_HALF_MIN && w_div <= DIV_FINE_MAX) || (w_div <= DIV_HALF_MAX && !w_div[0] && w_div > DIV_FINE_MAX)) begin
                    divide_ratio_setting <= w_div;
                end
            end
            if (paddr == SYNTH_OFFSET && w_num >= NUM_MIN && w_num <= NUM_MAX && w_den >= DEN_MIN && w_den <= DEN_MAX) begin
                synth_numerator   <= w_num;
                synth_denominator <= w_den;
            end
            if (paddr == SHIFT_OFFSET && (w_shift <= SHIFT_LIMIT || w_shift >= 9'(-SHIFT_LIMIT))) begin
                phase_shift <= w_shift;
            end
        end
    end

    // ==========================================
    // reference and feedback measurement
    logic        ref_prev;
    logic        fb_prev;
    logic        ref_rise;
    logic        ref_fall;
    logic        fb_rise;
    logic [15:0] ref_cnt;
    logic [15:0] high_time;
    logic [15:0] elapsed;
    logic        period_ok;
    logic [15:0] half;
    logic [15:0] quarter;

    assign ref_rise  = reference_clock_in && !ref_prev;
    assign ref_fall  = !reference_clock_in && ref_prev;
    assign fb_rise   = feedback_clock_in && !fb_prev;
    assign elapsed   = ref_rise ? 16'h0000 : ref_cnt;
    assign period_ok = period >= MIN_PERIOD;
    assign half      = period >> 1;
    assign quarter   = period >> 2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev  <= 1'b0;
            fb_prev   <= 1'b0;
            ref_cnt   <= 16'h0000;
            period    <= 16'h0000;
            high_time <= 16'h0000;
            stable    <= 1'b0;
        end else begin
            ref_prev <= reference_clock_in;
            fb_prev  <= feedback_clock_in;
            if (ref_rise) begin
                ref_cnt <= 16'h0001;
                period  <= ref_cnt;
                stable  <= (ref_cnt == period);
            end else if (ref_cnt != CNT_MAX) begin
                ref_cnt <= ref_cnt + 16'h0001;
            end
            if (ref_fall) begin
                high_time <= ref_cnt;
            end
        end
    end

    // ==========================================
    // fine shift and delay compensation
    logic        ps_neg;
    logic [8:0]  ps_mag;
    logic [24:0] ps_prod;
    logic [15:0] sc;
    logic [15:0] sh_off;
    logic [15:0] err;
    logic [15:0] err_fb;
    logic [15:0] comp;
    logic [15:0] target;
    logic [15:0] lphase;

    assign ps_neg  = phase_shift[8];
    assign ps_mag  = ps_neg ? 9'(-phase_shift) : phase_shift;
    assign ps_prod = {16'h0000, ps_mag} * {9'h000, period};
    // a step never falls below one clock, which stands for one tap
    assign sc      = (ps_mag != 9'h000 && ps_prod[24:FINE_STEP_LOG2] == 16'h0000) ? 16'h0001 : ps_prod[24:FINE_STEP_LOG2];
    assign sh_off  = ps_neg ? ((sc == 16'h0000) ? 16'h0000 : period - sc) : sc;
    assign err     = wrap_sub(elapsed, sh_off, period);
    assign err_fb  = (fb_mode == FB_2X && err >= half) ? err - half : err;
    assign target  = wrap_sub(comp, sh_off, period);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp    <= 16'h0000;
            aligned <= 1'b0;
        end else if (fb_mode == FB_NONE || !period_ok || comp >= period) begin
            comp    <= 16'h0000;
            aligned <= 1'b0;
        end else if (ref_rise && ref_cnt != period) begin
            aligned <= 1'b0;
        end else if (fb_rise) begin
            comp    <= wrap_add(comp, err_fb, period);
            aligned <= (err_fb == 16'h0000);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_indicator <= 1'b0;
        end else begin
            lock_indicator <= period_ok && stable && (fb_mode == FB_NONE || aligned);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lphase <= 16'h0000;
        end else if (ref_rise) begin
            lphase <= target;
        end else if (lphase >= period - 16'h0001) begin
            lphase <= 16'h0000;
        end else begin
            lphase <= lphase + 16'h0001;
        end
    end

    // ==========================================
    // four phase outputs
    logic [3:0]  phase_q;
    logic [15:0] thresh;

    assign thresh = dcc_enable ? half : high_time;

    for (genvar k = 0; k < 4; k++) begin : g_phase
        logic [15:0] off;
        assign off = (k == 0) ? 16'h0000 : (k == 1) ? quarter : (k == 2) ? half : half + quarter;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                phase_q[k] <= 1'b0;
            end else begin
                phase_q[k] <= period_ok && (wrap_sub(lphase, off, period) < thresh);
            end
        end
    end

    assign zero_phase_output          = phase_q[0];
    assign quarter_phase_output       = phase_q[1];
    assign half_phase_output          = phase_q[2];
    assign three_quarter_phase_output = phase_q[3];

    // ==========================================
    // doubled pair
    logic [15:0] dph;

    assign dph = (lphase >= half) ? lphase - half : lphase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            doubled_clock          <= 1'b0;
            doubled_clock_inverted <= 1'b0;
        end else begin
            // quarter-high at the reference rate until locked
            doubled_clock          <= period_ok && (lock_indicator ? dph < quarter : lphase < quarter);
            doubled_clock_inverted <= period_ok && lock_indicator && dph >= quarter;
        end
    end

    // ==========================================
    // divided clock
    logic        ph_zero;
    logic [21:0] dv_span;
    logic [20:0] dv_len;
    logic [20:0] dv_hi;
    logic [20:0] dv_cnt;
    logic [5:0]  dv_ref;
    logic        dv_trim;

    assign ph_zero = period_ok && lphase == 16'h0000;
    assign dv_span = {16'h0000, divide_ratio_setting} * {6'h00, period};
    assign dv_len  = dv_span[21:1];
    assign dv_hi   = dv_len >> 1;
    assign dv_trim = divide_ratio_setting[0] && high_freq && dv_hi > 21'h000001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dv_cnt        <= 21'h000000;
            dv_ref        <= 6'h00;
            divided_clock <= 1'b0;
        end else begin
            if (ph_zero) begin
                dv_ref <= (dv_ref >= divide_ratio_setting - 6'h01) ? 6'h00 : dv_ref + 6'h01;
            end
            if (ph_zero && dv_ref == 6'h00) begin
                dv_cnt <= 21'h000000;
            end else if (dv_cnt >= dv_len - 21'h000001) begin
                dv_cnt <= 21'h000000;
            end else begin
                dv_cnt <= dv_cnt + 21'h000001;
            end
            divided_clock <= period_ok && dv_cnt < (dv_trim ? dv_hi - 21'h000001 : dv_hi);
        end
    end

    // ==========================================
    // fractional synthesizer; toggles every span/(2*num) clocks
    logic [21:0] fx_span;
    logic [21:0] fx_step;
    logic [22:0] fx_sum;
    logic [21:0] fx_acc;
    logic [5:0]  fx_ref;

    assign fx_span = {16'h0000, synth_denominator} * {6'h00, period};
    assign fx_step = {15'h0000, synth_numerator, 1'b0};
    assign fx_sum  = {1'b0, fx_acc} + {1'b0, fx_step};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fx_acc                     <= 22'h000000;
            fx_ref                     <= 6'h00;
            synthesized_clock          <= 1'b0;
            synthesized_clock_inverted <= 1'b0;
        end else if (!period_ok) begin
            fx_acc                     <= 22'h000000;
            synthesized_clock          <= 1'b0;
            synthesized_clock_inverted <= 1'b0;
        end else begin
            if (ph_zero) begin
                fx_ref <= (fx_ref >= synth_denominator - 6'h01) ? 6'h00 : fx_ref + 6'h01;
            end
            if (ph_zero && fx_ref == 6'h00) begin
                fx_acc                     <= 22'h000000;
                synthesized_clock          <= 1'b1;
                synthesized_clock_inverted <= 1'b0;
            end else if (fx_sum >= {1'b0, fx_span}) begin
                fx_acc                     <= 22'(fx_sum - {1'b0, fx_span});
                synthesized_clock          <= !synthesized_clock;
                synthesized_clock_inverted <= synthesized_clock;
            end else begin
                fx_acc                     <= fx_sum[21:0];
                // keeps the pair inverse from the first valid cycle, before the first realign
                synthesized_clock_inverted <= !synthesized_clock;
            end
        end
    end

    // ==========================================
    // checks
    property p_fx_inverse;
        @(posedge pclk) disable iff (!presetn) period_ok ##1 period_ok |-> synthesized_clock_inverted == !synthesized_clock;
    endproperty
    a_fx_inverse: assert property (p_fx_inverse) else $error("synth pair not inverse");

    property p_ratio_range;
        @(posedge pclk) disable iff (!presetn)
            synth_numerator >= 6'h02 && synth_numerator <= 6'h20 && synth_denominator >= 6'h01 && synth_denominator <= 6'h20;
    endproperty
    a_ratio_range: assert property (p_ratio_range) else $error("synth ratio out of range");

    property p_div_range;
        @(posedge pclk) disable iff (!presetn) (divide_ratio_setting >= 6'h03 && divide_ratio_setting <= 6'h10)
            || (divide_ratio_setting <= 6'h20 && !divide_ratio_setting[0]);
    endproperty
    a_div_range: assert property (p_div_range) else $error("divide ratio illegal");

    property p_prelock_quarter;
        @(posedge pclk) disable iff (!presetn) !lock_indicator && period_ok && lphase == quarter |=> !doubled_clock;
    endproperty
    a_prelock_quarter: assert property (p_prelock_quarter) else $error("doubled high past quarter before lock");

    property p_edge_aligned;
        @(posedge pclk) disable iff (!presetn)
            ref_rise && target == 16'h0000 && period_ok && $stable(period) |-> ##2 zero_phase_output && doubled_clock;
    endproperty
    a_edge_aligned: assert property (p_edge_aligned) else $error("doubled not rising with zero phase");

    property p_dcc_half;
        @(posedge pclk) disable iff (!presetn) dcc_enable && period_ok && lphase == half ##1 $stable(dcc_enable) |-> !zero_phase_output;
    endproperty
    a_dcc_half: assert property (p_dcc_half) else $error("zero phase high past half period");

    property p_lock_cause;
        @(posedge pclk) disable iff (!presetn) $rose(lock_indicator) |-> $past(stable) && $past(period_ok);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without stable period");

    property p_no_fb_comp;
        @(posedge pclk) disable iff (!presetn) fb_mode == FB_NONE |=> comp == 16'h0000;
    endproperty
    a_no_fb_comp: assert property (p_no_fb_comp) else $error("compensation without feedback");

    property p_fine_step;
        @(posedge pclk) disable iff (!presetn) phase_shift != 9'h000 && period_ok |-> sc != 16'h0000;
    endproperty
    a_fine_step: assert property (p_fine_step) else $error("fine step below one tap");

endmodule : clock_frequency_synthesis

// File: src/clock_synth_pkg.sv
// register map, field layout and limits of the clock synthesis block
package clock_synth_pkg;
    // ==========================================
    // bus
    localparam int          PADDR_W        = 12;
    localparam int          PDATA_W        = 32;
    localparam logic [11:0] CTRL_OFFSET    = 12'h000;
    localparam logic [11:0] SYNTH_OFFSET   = 12'h004;
    localparam logic [11:0] SHIFT_OFFSET   = 12'h008;
    localparam logic [11:0] STATUS_OFFSET  = 12'h00C;
    // ==========================================
    // field positions
    localparam int          CTRL_DCC_BIT   = 0;
    localparam int          CTRL_FB_LSB    = 1;
    localparam int          CTRL_HF_BIT    = 3;
    localparam int          CTRL_DIV_LSB   = 8;
    localparam int          SYNTH_NUM_LSB  = 0;
    localparam int          SYNTH_DEN_LSB  = 8;
    localparam int          STAT_LOCK_BIT  = 0;
    localparam int          STAT_STBL_BIT  = 1;
    localparam int          STAT_ALGN_BIT  = 2;
    localparam int          STAT_PER_LSB   = 16;
    // ==========================================
    // reset values
    localparam logic        DCC_RESET      = 1'b1;
    localparam logic [1:0]  FB_RESET       = 2'h1;
    localparam logic        HF_RESET       = 1'b0;
    localparam logic [5:0]  DIV_RESET      = 6'h04;
    localparam logic [5:0]  NUM_RESET      = 6'h02;
    localparam logic [5:0]  DEN_RESET      = 6'h01;
    localparam logic [8:0]  SHIFT_RESET    = 9'h000;
    // ==========================================
    // feedback source codes
    localparam logic [1:0]  FB_NONE        = 2'h0;
    localparam logic [1:0]  FB_1X          = 2'h1;
    localparam logic [1:0]  FB_2X          = 2'h2;
    // ==========================================
    // limits; divide ratio is held in half steps
    localparam logic [5:0]  DIV_HALF_MIN   = 6'h03;
    localparam logic [5:0]  DIV_FINE_MAX   = 6'h10;
    localparam logic [5:0]  DIV_HALF_MAX   = 6'h20;
    localparam logic [5:0]  NUM_MIN        = 6'h02;
    localparam logic [5:0]  NUM_MAX        = 6'h20;
    localparam logic [5:0]  DEN_MIN        = 6'h01;
    localparam logic [5:0]  DEN_MAX        = 6'h20;
    localparam logic [8:0]  SHIFT_LIMIT    = 9'h0FF;
    localparam int          FINE_STEP_LOG2 = 9;
    localparam logic [15:0] MIN_PERIOD     = 16'h0004;
    localparam logic [15:0] CNT_MAX        = 16'hFFFF;
endpackage : clock_synth_pkg

// File: verification/ref_clock_source.sv
// partner: reference clock source and feedback routing
`timescale 1ns/1ps
module ref_clock_source #(
    parameter int         PERIOD    = 16,
    parameter int         HIGH_TIME = 4,
    parameter logic [1:0] FB        = 2'h1
) (
    input  wire logic pclk,
    input  wire logic zero_phase_output,
    input  wire logic doubled_clock,
    output logic      reference_clock_in,
    output logic      feedback_clock_in
);
    int phase = 0;
    // ======
    // reference, uneven duty on purpose to expose missing correction
    always_ff @(posedge pclk) begin
        phase <= (phase + 1) % PERIOD;
    end
    assign reference_clock_in = phase < HIGH_TIME;
    // ======
    // feedback wiring follows the configured source; none idles low
    assign feedback_clock_in = (FB == 2'h1) ? zero_phase_output : (FB == 2'h2) ? doubled_clock : 1'b0;
endmodule : ref_clock_source

// File: verification/tb.sv
// bench: register access and clock waveform measurements
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb;
    import clock_synth_pkg::*;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [PDATA_W-1:0] pwdata = '0, prdata, rd;
    logic               pready, pslverr, er, rc, fc, z, q, h, t, d2, d2i, dv, sx, sxi, lk;
    int                 miscompares = 0, compares = 0, rs[4], hs[5], qs[3], bad;
    int                 hv[5] = '{3, 5, 16, 20, 32}, nm[3] = '{3, 5, 2}, dn[3] = '{2, 3, 1}, ex[3] = '{18, 20, 24};
    always #20 pclk = ~pclk;
    clock_frequency_synthesis DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock_in(rc), .feedback_clock_in(fc), .zero_phase_output(z), .quarter_phase_output(q),
        .half_phase_output(h), .three_quarter_phase_output(t), .doubled_clock(d2), .doubled_clock_inverted(d2i),
        .divided_clock(dv), .synthesized_clock(sx), .synthesized_clock_inverted(sxi), .lock_indicator(lk));
    ref_clock_source #(.PERIOD(16), .HIGH_TIME(4), .FB(FB_1X)) partner (.pclk(pclk), .zero_phase_output(z),
        .doubled_clock(d2), .reference_clock_in(rc), .feedback_clock_in(fc));
    // ======
    // apb transfer; waits on pready, never a fixed count
    task apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) miscompares++;
    endtask : apb
    // ======
    // window must be a whole number of every measured period
    task meas(input int w);
        logic [3:0] v, pv;
        #1;
        pv = {sx, dv, d2, z};
        rs = '{default: 0};
        hs = '{default: 0};
        qs = '{default: 0};
        bad = 0;
        repeat (w) begin
            @(posedge pclk);
            #1;
            v = {sx, dv, d2, z};
            for (int k = 0; k < 4; k++) begin
                rs[k] += int'(v[k] && !pv[k]);
                hs[k] += int'(v[k]);
            end
            hs[4] += int'(d2i);
            qs[0] += int'(q) + int'(h) + int'(t);
            qs[1] += int'(v[0] && !pv[0] && t && !q);
            qs[2] += int'(v[0] && !pv[0] && rc);
            bad += int'(sx === sxi) + int'(d2 && d2i);
            pv = v;
        end
    endtask : meas
    task end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(CTRL_OFFSET, 1'b0, 32'h0);
        `CHK("ctrl reset", 32'h00000403, rd)
        apb(SYNTH_OFFSET, 1'b0, 32'h0);
        `CHK("synth reset", 32'h00000102, rd)
        apb(12'h010, 1'b0, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        for (int n = 0; n < 2000 && lk !== 1'b1; n++) @(posedge pclk);
        `CHK("lock", 1'b1, lk)
        $display("test reset done");
        for (int c = 0; c < 2; c++) begin
            apb(CTRL_OFFSET, 1'b1, 32'h00000402 | c);
            repeat (256) @(posedge pclk);
            meas(64);
            `CHK("zero high", c ? 32 : 16, hs[0])
            `CHK("zero rises", 4, rs[0])
            `CHK("dbl rises", 8, rs[1])
            `CHK("dbl high", 32, hs[1])
            `CHK("dbl inv high", 32, hs[4])
            `CHK("inverse pairs", 0, bad)
            `CHK("phase highs", c ? 96 : 48, qs[0])
            `CHK("phase order", c ? 4 : 0, qs[1])
            `CHK("zero at ref", 4, qs[2])
        end
        $display("test duty done");
        foreach (hv[i]) begin
            apb(CTRL_OFFSET, 1'b1, 32'(hv[i] << 8) | 32'h3);
            repeat (32 * hv[i]) @(posedge pclk);
            meas(16 * hv[i]);
            `CHK("div rises", 2, rs[2])
            `CHK("div high", 8 * hv[i], hs[2])
        end
        apb(CTRL_OFFSET, 1'b1, 32'h00001103);
        apb(CTRL_OFFSET, 1'b0, 32'h0);
        `CHK("div kept", 32'h00002003, rd)
        apb(CTRL_OFFSET, 1'b1, 32'h0000050B);
        repeat (160) @(posedge pclk);
        meas(80);
        `CHK("div hf rises", 2, rs[2])
        `CHK("div hf high", 38, hs[2])
        $display("test divide done");
        foreach (nm[i]) begin
            apb(SYNTH_OFFSET, 1'b1, 32'(dn[i] << 8) | 32'(nm[i]));
            repeat (400) @(posedge pclk);
            meas(192);
            `CHK("synth rises", ex[i], rs[3])
            `CHK("synth high", 96, hs[3])
            `CHK("inverse pairs", 0, bad)
            `CHK("zero alongside", 12, rs[0])
        end
        apb(SYNTH_OFFSET, 1'b1, 32'h00000101);
        apb(SYNTH_OFFSET, 1'b1, 32'h00000121);
        apb(SYNTH_OFFSET, 1'b0, 32'h0);
        `CHK("synth kept", 32'h00000102, rd)
        $display("test synth done");
        // minus 32 steps of a 16-cycle period, one clock: feedback lands one cycle before the reference
        apb(SHIFT_OFFSET, 1'b1, 32'h000001E0);
        apb(SHIFT_OFFSET, 1'b1, 32'h00000100);
        repeat (256) @(posedge pclk);
        meas(64);
        `CHK("shift edge", 0, qs[2])
        `CHK("shift zero rises", 4, rs[0])
        apb(SHIFT_OFFSET, 1'b0, 32'h0);
        `CHK("shift kept", 32'h000001E0, rd)
        $display("test shift done");
        apb(CTRL_OFFSET, 1'b1, 32'h00000401);
        repeat (64) @(posedge pclk);
        apb(STATUS_OFFSET, 1'b0, 32'h0);
        `CHK("no fb status", 3'h3, rd[2:0])
        `CHK("period", 16, rd[31:16])
        apb(STATUS_OFFSET, 1'b1, 32'h0);
        `CHK("status write err", 1'b0, er)
        apb(STATUS_OFFSET, 1'b0, 32'h0);
        `CHK("status lock", 1'b1, rd[STAT_LOCK_BIT])
        $display("test status done");
        end_of_test();
    end
endmodule : tb
